// [host_parallel_debug_link_port_tb.sv]
// Bench: board end and host end joined by one link, plus a second board end on a bench-driven link.
// Assumes the package constants; stimulus changes on the falling edge of a 125 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module host_parallel_debug_link_port_tb;
    import hpl_pkg::*;
    localparam int BA = 5;
    logic mclk = 1'b0, rst_n = 1'b0, h_txv = 1'b0, b_txv = 1'b0, soft_req = 1'b0, hard_req = 1'b0;
    logic h_txr, b_txr, h_rxv, b_rxv, soft_rst, soft_cfg, hard_rst, active, b_active;
    logic [7:0] h_txd = 8'h00, b_txd = 8'h00, noise = 8'h00, h_rxd, b_rxd;
    logic [2:0] target = 3'h5;
    logic [15:0] seed = 16'h7467;
    logic [7:0] exp_h2b[$], exp_b2h[$];
    int num_errors = 0, compares = 0, last_wait = 0;
    hpl_link_if link_a();
    hpl_link_if link_b();
    // A released bus shows a changing pattern, never its last value.
    assign link_a.parallel_data_bus = link_a.pd_board_oe ? link_a.pd_board_out : (link_a.pd_host_oe ? link_a.pd_host_out : noise);
    assign link_b.parallel_data_bus = link_b.pd_board_oe ? link_b.pd_board_out : (link_b.pd_host_oe ? link_b.pd_host_out : noise);
    hpl_board_end #(.BOARD_ADDR(BA), .RST_CYC(1)) hpl_board_end_inst (.MCLK(mclk), .RST_N(rst_n), .LINK(link_a.board),
        .TX_DATA(b_txd), .TX_VALID(b_txv), .TX_READY(b_txr), .RX_DATA(b_rxd), .RX_VALID(b_rxv),
        .SOFT_RESET(soft_rst), .SOFT_CONFIG(soft_cfg), .HARD_RESET(hard_rst), .LINK_ACTIVE(active));
    hpl_board_end #(.BOARD_ADDR(BA), .RST_CYC(1)) hpl_board_end_inst_b (.MCLK(mclk), .RST_N(rst_n), .LINK(link_b.board),
        .TX_DATA(8'h00), .TX_VALID(1'b0), .TX_READY(), .RX_DATA(), .RX_VALID(),
        .SOFT_RESET(), .SOFT_CONFIG(), .HARD_RESET(), .LINK_ACTIVE(b_active));
    hpl_host_end hpl_host_end_inst (.MCLK(mclk), .RST_N(rst_n), .LINK(link_a.host), .TARGET_ADDR(target),
        .SOFT_REQ(soft_req), .HARD_REQ(hard_req), .TX_DATA(h_txd), .TX_VALID(h_txv), .TX_READY(h_txr),
        .RX_DATA(h_rxd), .RX_VALID(h_rxv));
    hpl_link_assertions #(.BOARD_ADDR(BA)) hpl_link_assertions_inst (.MCLK(mclk), .RST_N(rst_n),
        .slave_addr(link_a.slave_addr), .host_req(link_a.host_req), .board_ack(link_a.board_ack),
        .board_req(link_a.board_req), .board_req_oe(link_a.board_req_oe), .host_ack(link_a.host_ack),
        .pd_board_oe(link_a.pd_board_oe), .pd_host_oe(link_a.pd_host_oe), .parallel_data_bus(link_a.parallel_data_bus));
    always #4 mclk = ~mclk;
    always @(negedge mclk) noise <= noise + 8'h35;
    // ==========================================================
    // Shared tasks
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic summarize();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic pop_chk(ref logic [7:0] q[$], input logic [7:0] seen);
        check(8'(q.size() != 0), 8'h01);
        if (q.size() != 0) check(seen, q.pop_front());
    endtask : pop_chk
    // Words go out back to back; valid stays up between them and drops once at the end.
    task automatic send(input logic to_board, input int n);
        int w;
        repeat (n) begin
            seed = lfsr_next(seed);
            if (to_board) begin
                h_txd = seed[7:0];
                h_txv = 1'b1;
                exp_h2b.push_back(seed[7:0]);
            end else begin
                b_txd = seed[7:0];
                b_txv = 1'b1;
                exp_b2h.push_back(seed[7:0]);
            end
            w = 0;
            do begin
                @(posedge mclk);
                w++;
            end while ((to_board ? h_txr : b_txr) !== 1'b1 && w < 400);
            last_wait = w;
            if (w >= 400) begin
                num_errors++;
                summarize();
            end
            @(negedge mclk);
        end
        if (to_board) h_txv = 1'b0;
        else b_txv = 1'b0;
    endtask : send
    task automatic drain();
        int n;
        n = 0;
        while (exp_h2b.size() + exp_b2h.size() != 0 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        check(8'(n < 400), 8'h01);
    endtask : drain
    always @(posedge mclk) begin
        if (b_rxv === 1'b1) pop_chk(exp_h2b, b_rxd);
        if (h_rxv === 1'b1) pop_chk(exp_b2h, h_rxd);
    end
    initial begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        summarize();
    end
    // ==========================================================
    // Main sequence
    initial begin
        link_b.slave_addr = 3'h5;
        link_b.host_soft_reset_req = 1'b0;
        link_b.host_hard_reset_req = 1'b0;
        link_b.host_present_n = 1'b1;
        link_b.host_power = 3'h0;
        link_b.host_req = 1'b0;
        link_b.host_ack = 1'b0;
        link_b.pd_host_out = 8'h00;
        link_b.pd_host_oe = 1'b0;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        send(1'b1, 6);
        send(1'b0, 6);
        check(8'(last_wait > 1), 8'h01);
        fork
            send(1'b1, 4);
            send(1'b0, 4);
        join
        drain();
        for (int k = 1; k < 4; k++) begin
            soft_req = k[0];
            hard_req = k[1];
            repeat (8) @(negedge mclk);
            check(8'({soft_rst, soft_cfg, hard_rst}), 8'(k == 1 ? 3'h6 : (k == 2 ? 3'h1 : 3'h0)));
            soft_req = 1'b0;
            hard_req = 1'b0;
            repeat (16) @(negedge mclk);
            check(8'({soft_rst, soft_cfg, hard_rst}), 8'h00);
        end
        send(1'b1, 2);
        send(1'b0, 2);
        drain();
        target = 3'h2;
        repeat (4) @(negedge mclk);
        soft_req = 1'b1;
        repeat (8) @(negedge mclk);
        check(8'(soft_rst), 8'h00);
        soft_req = 1'b0;
        repeat (6) @(negedge mclk);
        target = 3'h5;
        // The second link breaks host presence and power on purpose, then picks another address.
        for (int k = 0; k < 5; k++) begin
            link_b.host_present_n = (k == 0);
            link_b.host_power = (k == 1) ? 3'h3 : 3'h7;
            link_b.slave_addr = (k == 4) ? 3'h4 : 3'h5;
            link_b.pd_host_out = seed[7:0];
            link_b.pd_host_oe = 1'b1;
            link_b.host_req = 1'b1;
            repeat (2) @(negedge mclk);
            check(8'(link_b.board_ack), 8'h00);
            repeat (6) @(negedge mclk);
            check(8'({b_active, link_b.board_ack, link_b.board_ack_oe, link_b.pd_board_oe}),
                8'(k < 2 ? 4'h0 : (k < 4 ? 4'hE : 4'h8)));
            link_b.host_req = 1'b0;
            link_b.pd_host_oe = 1'b0;
            repeat (8) @(negedge mclk);
            check(8'(link_b.board_ack), 8'h00);
        end
        drain();
        summarize();
    end
endmodule : host_parallel_debug_link_port_tb
`default_nettype wire

// [hpl_board_end.sv]
// Board end of the parallel host link: select decode, reset requests, two handshakes.
// Assumes every link input is asynchronous to MCLK; the two-entry buffer sits on the board-to-host path.
// How it works
// - Respond only when select matches own address.
// - Selected soft request issues processor soft reset.
// - Host holds host-present low while attached.
// - Link works only while host-present low.
// - Host absent means all outputs released.
// - Hard request plus match gives hard reset.
// - Both requests reset the link's own state.
// - Host raises request to send a byte.
// - Board acknowledges a seen host request.
// - Board raises request to send a byte.
// - Host answers board request with acknowledge.
// - Host powered only while power lines present.
// - One shared 8-bit bus, sender drives.
`timescale 1ns/1ns
`default_nettype none
module hpl_board_end #(
    parameter int BOARD_ADDR = 0,
    parameter int RST_CYC = hpl_pkg::HPL_RST_PULSE_CYC
) (
    input wire logic MCLK,
    input wire logic RST_N,
    hpl_link_if.board LINK,
    input wire logic [hpl_pkg::HPL_DATA_W-1:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic [hpl_pkg::HPL_DATA_W-1:0] RX_DATA,
    output logic RX_VALID,
    output logic SOFT_RESET,
    output logic SOFT_CONFIG,
    output logic HARD_RESET,
    output logic LINK_ACTIVE
);
    import hpl_pkg::*;

    initial begin
        if (BOARD_ADDR < 0 || BOARD_ADDR >= (1 << HPL_ADDR_W)) $error("BOARD_ADDR out of range");
        if (RST_CYC < 1 || RST_CYC > 255) $error("RST_CYC out of range");
    end

    // ==========================================================
    // Input synchronisers
    localparam int IN_W = HPL_ADDR_W + HPL_PWR_LINES + HPL_DATA_W + 5;
    logic [IN_W-1:0] raw_in;
    logic [IN_W-1:0] s1_r, s2_r, s1_nxt, s2_nxt;
    assign raw_in = {LINK.slave_addr, LINK.host_power, LINK.parallel_data_bus, LINK.host_soft_reset_req,
                     LINK.host_hard_reset_req, LINK.host_present_n, LINK.host_req, LINK.host_ack};
    always_comb begin
        s1_nxt = raw_in;
        s2_nxt = s1_r;
    end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_r <= '0;
            s2_r <= {{(IN_W-3){1'b0}}, 3'h4};
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end
    logic [HPL_ADDR_W-1:0] sel_s;
    logic [HPL_PWR_LINES-1:0] pwr_s;
    logic [HPL_DATA_W-1:0] pd_s;
    logic srst_s, hrst_s, present_n_s, hreq_s, hack_s;
    assign {sel_s, pwr_s, pd_s, srst_s, hrst_s, present_n_s, hreq_s, hack_s} = s2_r;

    // ==========================================================
    // Qualification
    logic powered, enabled, selected, link_clear;
    assign powered = &pwr_s;
    assign enabled = !present_n_s && powered;
    assign selected = enabled && (sel_s == BOARD_ADDR[HPL_ADDR_W-1:0]);
    assign link_clear = selected && srst_s && hrst_s;

    // ==========================================================
    // Reset requests to the processor
    logic soft_r, soft_nxt, hard_r, hard_nxt;
    logic [7:0] rcnt_r, rcnt_nxt;
    always_comb begin
        soft_nxt = 1'b0;
        hard_nxt = 1'b0;
        rcnt_nxt = HPL_RST_CNT_ZERO;
        if (selected && hrst_s && !srst_s) begin
            hard_nxt = 1'b1;
            rcnt_nxt = RST_CYC[7:0];
        end else if (selected && srst_s && !hrst_s) begin
            soft_nxt = 1'b1;
            rcnt_nxt = RST_CYC[7:0];
        end else if (rcnt_r != HPL_RST_CNT_ZERO) begin
            rcnt_nxt = rcnt_r - 8'h01;
            soft_nxt = soft_r;
            hard_nxt = hard_r;
        end
    end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            soft_r <= 1'b0;
            hard_r <= 1'b0;
            rcnt_r <= HPL_RST_CNT_ZERO;
        end else begin
            soft_r <= soft_nxt;
            hard_r <= hard_nxt;
            rcnt_r <= rcnt_nxt;
        end
    end

    // ==========================================================
    // Host to board handshake
    // Data is sampled once the synchronised request is seen; the host holds it stable until acknowledge.
    logic hack_r, hack_nxt, rxv_r, rxv_nxt;
    logic [HPL_DATA_W-1:0] rxd_r, rxd_nxt;
    always_comb begin
        hack_nxt = hack_r;
        rxv_nxt = 1'b0;
        rxd_nxt = rxd_r;
        if (link_clear || !selected) begin
            hack_nxt = 1'b0;
        end else if (hreq_s && !hack_r) begin
            hack_nxt = 1'b1;
            rxv_nxt = 1'b1;
            rxd_nxt = pd_s;
        end else if (!hreq_s && hack_r) begin
            hack_nxt = 1'b0;
        end
    end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            hack_r <= 1'b0;
            rxv_r <= 1'b0;
            rxd_r <= HPL_DATA_ZERO;
        end else begin
            hack_r <= hack_nxt;
            rxv_r <= rxv_nxt;
            rxd_r <= rxd_nxt;
        end
    end

    // ==========================================================
    // Two-entry buffer ahead of the board to host sender
    logic [HPL_DATA_W-1:0] buf_r [2];
    logic [HPL_DATA_W-1:0] buf_nxt [2];
    logic [1:0] cnt_r, cnt_nxt;
    logic buf_pop, buf_push;
    assign buf_push = TX_VALID && TX_READY;
    always_comb begin
        buf_nxt = buf_r;
        cnt_nxt = cnt_r;
        if (buf_pop) begin
            buf_nxt[0] = buf_r[1];
            cnt_nxt = cnt_nxt - 2'h1;
        end
        if (buf_push) begin
            buf_nxt[cnt_nxt[0]] = TX_DATA;
            cnt_nxt = cnt_nxt + 2'h1;
        end
    end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            buf_r[0] <= HPL_DATA_ZERO;
            buf_r[1] <= HPL_DATA_ZERO;
            cnt_r <= 2'h0;
            TX_READY <= 1'b0;
        end else begin
            buf_r <= buf_nxt;
            cnt_r <= link_clear ? 2'h0 : cnt_nxt;
            // Ready is registered, so it looks one word ahead: only free space after this cycle counts.
            TX_READY <= !link_clear && (cnt_nxt < HPL_BUF_DEPTH - 2'h1 || (cnt_nxt < HPL_BUF_DEPTH && !buf_push));
        end
    end

    // ==========================================================
    // Board to host handshake
    hpl_hs_t st_r, st_nxt;
    logic breq_r, breq_nxt, drv_r, drv_nxt;
    logic [2:0] gcnt_r, gcnt_nxt;
    logic [HPL_DATA_W-1:0] txd_r, txd_nxt;
    always_comb begin
        st_nxt = st_r;
        gcnt_nxt = gcnt_r;
        breq_nxt = breq_r;
        drv_nxt = drv_r;
        txd_nxt = txd_r;
        buf_pop = 1'b0;
        unique case (st_r)
            HPL_IDLE: begin
                // Request first, drive after the guard time: a crossing host request withdraws ours.
                if (selected && !link_clear && cnt_r != 2'h0 && !hack_s && !hreq_s && !hack_r) begin
                    breq_nxt = 1'b1;
                    if (gcnt_r == HPL_GUARD_CYC) begin
                        buf_pop = 1'b1;
                        txd_nxt = buf_r[0];
                        drv_nxt = 1'b1;
                        gcnt_nxt = '0;
                        st_nxt = HPL_WAIT_ACK;
                    end else begin
                        gcnt_nxt = gcnt_r + 3'h1;
                    end
                end else begin
                    breq_nxt = 1'b0;
                    gcnt_nxt = '0;
                end
            end
            HPL_WAIT_ACK: begin
                if (hack_s) begin
                    breq_nxt = 1'b0;
                    drv_nxt = 1'b0;
                    st_nxt = HPL_WAIT_REL;
                end
            end
            HPL_WAIT_REL: begin
                if (!hack_s) st_nxt = HPL_IDLE;
            end
        endcase
        if (link_clear || !selected) begin
            st_nxt = HPL_IDLE;
            gcnt_nxt = '0;
            breq_nxt = 1'b0;
            drv_nxt = 1'b0;
        end
    end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r <= HPL_IDLE;
            gcnt_r <= '0;
            breq_r <= 1'b0;
            drv_r <= 1'b0;
            txd_r <= HPL_DATA_ZERO;
        end else begin
            st_r <= st_nxt;
            gcnt_r <= gcnt_nxt;
            breq_r <= breq_nxt;
            drv_r <= drv_nxt;
            txd_r <= txd_nxt;
        end
    end

    // ==========================================================
    // Pin and user outputs
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            LINK.board_ack <= 1'b0;
            LINK.board_ack_oe <= 1'b0;
            LINK.board_req <= 1'b0;
            LINK.board_req_oe <= 1'b0;
            LINK.pd_board_out <= HPL_DATA_ZERO;
            LINK.pd_board_oe <= 1'b0;
            RX_DATA <= HPL_DATA_ZERO;
            RX_VALID <= 1'b0;
            SOFT_RESET <= 1'b0;
            SOFT_CONFIG <= 1'b0;
            HARD_RESET <= 1'b0;
            LINK_ACTIVE <= 1'b0;
        end else begin
            LINK.board_ack <= hack_nxt;
            LINK.board_ack_oe <= selected;
            LINK.board_req <= breq_nxt;
            LINK.board_req_oe <= selected;
            LINK.pd_board_out <= txd_nxt;
            LINK.pd_board_oe <= drv_nxt && selected;
            RX_DATA <= rxd_nxt;
            RX_VALID <= rxv_nxt;
            SOFT_RESET <= soft_nxt;
            SOFT_CONFIG <= soft_nxt;
            HARD_RESET <= hard_nxt;
            LINK_ACTIVE <= enabled;
        end
    end
endmodule : hpl_board_end
`default_nettype wire

// [hpl_host_end.sv]
// Host adapter end of the parallel host link.
// Assumes board outputs are asynchronous; user side is on MCLK.
`timescale 1ns/1ns
`default_nettype none
module hpl_host_end (
    input wire logic MCLK,
    input wire logic RST_N,
    hpl_link_if.host LINK,
    input wire logic [hpl_pkg::HPL_ADDR_W-1:0] TARGET_ADDR,
    input wire logic SOFT_REQ,
    input wire logic HARD_REQ,
    input wire logic [hpl_pkg::HPL_DATA_W-1:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic [hpl_pkg::HPL_DATA_W-1:0] RX_DATA,
    output logic RX_VALID
);
    import hpl_pkg::*;

    // ==========================================================
    // Synchronisers on board outputs
    logic [HPL_DATA_W+1:0] s1_r, s2_r;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= {LINK.parallel_data_bus, LINK.board_req & LINK.board_req_oe, LINK.board_ack & LINK.board_ack_oe};
            s2_r <= s1_r;
        end
    end
    logic [HPL_DATA_W-1:0] pd_s;
    logic breq_s, back_s;
    assign {pd_s, breq_s, back_s} = s2_r;

    // ==========================================================
    // Host to board sender and board to host receiver
    hpl_hs_t st_r, st_nxt;
    logic req_r, req_nxt, oe_r, oe_nxt, ack_r, ack_nxt, rxv_nxt, pend_r, pend_nxt;
    logic [2:0] hcnt_r, hcnt_nxt;
    logic [HPL_DATA_W-1:0] d_r, d_nxt, rxd_nxt;
    always_comb begin
        st_nxt = st_r;
        req_nxt = req_r;
        oe_nxt = oe_r;
        d_nxt = d_r;
        ack_nxt = ack_r;
        pend_nxt = pend_r;
        hcnt_nxt = hcnt_r;
        rxv_nxt = 1'b0;
        rxd_nxt = RX_DATA;
        unique case (st_r)
            HPL_IDLE: begin
                // A word taken from the user waits here while the board holds the link.
                if (pend_r && !breq_s && !ack_r && !back_s) begin
                    oe_nxt = 1'b1;
                    req_nxt = 1'b1;
                    pend_nxt = 1'b0;
                    st_nxt = HPL_WAIT_ACK;
                end
                if (TX_VALID && TX_READY) begin
                    d_nxt = TX_DATA;
                    pend_nxt = 1'b1;
                end
            end
            HPL_WAIT_ACK: begin
                if (back_s) begin
                    req_nxt = 1'b0;
                    oe_nxt = 1'b0;
                    st_nxt = HPL_WAIT_REL;
                end
            end
            HPL_WAIT_REL: begin
                if (!back_s) st_nxt = HPL_IDLE;
            end
        endcase
        // The board drives data only after its guard time, so the request must stand as long here.
        if (breq_s && !ack_r && st_r == HPL_IDLE) begin
            if (hcnt_r == HPL_GUARD_CYC) begin
                ack_nxt = 1'b1;
                rxv_nxt = 1'b1;
                rxd_nxt = pd_s;
                hcnt_nxt = '0;
            end else begin
                hcnt_nxt = hcnt_r + 3'h1;
            end
        end else begin
            hcnt_nxt = '0;
            if (!breq_s) ack_nxt = 1'b0;
        end
    end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r <= HPL_IDLE;
            req_r <= 1'b0;
            oe_r <= 1'b0;
            d_r <= HPL_DATA_ZERO;
            ack_r <= 1'b0;
            pend_r <= 1'b0;
            hcnt_r <= '0;
            RX_VALID <= 1'b0;
            RX_DATA <= HPL_DATA_ZERO;
            TX_READY <= 1'b0;
            LINK.host_present_n <= 1'b0;
            LINK.host_power <= '1;
            LINK.slave_addr <= '0;
            LINK.host_soft_reset_req <= 1'b0;
            LINK.host_hard_reset_req <= 1'b0;
            LINK.host_req <= 1'b0;
            LINK.host_ack <= 1'b0;
            LINK.pd_host_out <= HPL_DATA_ZERO;
            LINK.pd_host_oe <= 1'b0;
        end else begin
            st_r <= st_nxt;
            req_r <= req_nxt;
            oe_r <= oe_nxt;
            d_r <= d_nxt;
            ack_r <= ack_nxt;
            pend_r <= pend_nxt;
            hcnt_r <= hcnt_nxt;
            RX_VALID <= rxv_nxt;
            RX_DATA <= rxd_nxt;
            TX_READY <= (st_nxt == HPL_IDLE) && !pend_nxt;
            LINK.host_present_n <= 1'b0;
            LINK.host_power <= '1;
            LINK.slave_addr <= TARGET_ADDR;
            LINK.host_soft_reset_req <= SOFT_REQ;
            LINK.host_hard_reset_req <= HARD_REQ;
            LINK.host_req <= req_nxt;
            LINK.host_ack <= ack_nxt;
            LINK.pd_host_out <= d_nxt;
            LINK.pd_host_oe <= oe_nxt;
        end
    end
endmodule : hpl_host_end
`default_nettype wire

// [hpl_link_assertions.sv]
// Concurrent checks on the link that joins the board end and the host end.
// Assumes one clock domain; the testbench instantiates it beside the interface.
`timescale 1ns/1ns
`default_nettype none
module hpl_link_assertions #(
    parameter int BOARD_ADDR = 0
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [hpl_pkg::HPL_ADDR_W-1:0] slave_addr,
    input wire logic host_req,
    input wire logic board_ack,
    input wire logic board_req,
    input wire logic board_req_oe,
    input wire logic host_ack,
    input wire logic pd_board_oe,
    input wire logic pd_host_oe,
    input wire logic [hpl_pkg::HPL_DATA_W-1:0] parallel_data_bus
);
    import hpl_pkg::*;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    // ==========================================================
    // Handshake steps
    sequence s_host_start;
        $rose(host_req) ##0 (slave_addr == HPL_ADDR_W'(BOARD_ADDR));
    endsequence
    sequence s_unsel;
        (slave_addr != HPL_ADDR_W'(BOARD_ADDR)) [*4];
    endsequence
    ack_answer_a: assert property (s_host_start |-> ##[1:6] board_ack) else $error("ack late");
    ack_hold_a: assert property (board_ack && host_req |=> board_ack) else $error("ack dropped early");
    ack_release_a: assert property ($fell(host_req) |-> ##[1:6] !board_ack) else $error("ack stuck");
    ack_cause_a: assert property ($rose(board_ack) |-> $past(host_req, 2)) else $error("ack too fast");
    host_answer_a: assert property ($rose(pd_board_oe) |-> ##[1:6] host_ack) else $error("host ack late");
    req_hold_a: assert property (pd_board_oe && !host_ack |=> board_req) else $error("request dropped");
    board_drive_a: assert property (pd_board_oe |-> board_req && board_req_oe) else $error("drive without request");
    data_stable_a: assert property ((pd_board_oe && $past(pd_board_oe)) || (host_req && $past(host_req))
        |-> $stable(parallel_data_bus)) else $error("data moved");
    bus_single_a: assert property (!(pd_board_oe && pd_host_oe)) else $error("bus contention");
    unsel_quiet_a: assert property (s_unsel |-> !pd_board_oe && !board_ack) else $error("unselected drive");
endmodule : hpl_link_assertions
`default_nettype wire

// [hpl_link_if.sv]
// Pin-level bundle of the parallel host link between board and host adapter.
// The testbench resolves the shared data bus from the two output enables.
`timescale 1ns/1ns
`default_nettype none
interface hpl_link_if;
    import hpl_pkg::*;
    logic [HPL_ADDR_W-1:0] slave_addr;
    logic host_soft_reset_req;
    logic host_hard_reset_req;
    logic host_present_n;
    logic [HPL_PWR_LINES-1:0] host_power;
    logic host_req;
    logic board_ack;
    logic board_ack_oe;
    logic board_req;
    logic board_req_oe;
    logic host_ack;
    logic [HPL_DATA_W-1:0] pd_host_out;
    logic pd_host_oe;
    logic [HPL_DATA_W-1:0] pd_board_out;
    logic pd_board_oe;
    logic [HPL_DATA_W-1:0] parallel_data_bus;
    modport board (
        input slave_addr, host_soft_reset_req, host_hard_reset_req, host_present_n, host_power,
        input host_req, host_ack, parallel_data_bus,
        output board_ack, board_ack_oe, board_req, board_req_oe, pd_board_out, pd_board_oe
    );
    modport host (
        output slave_addr, host_soft_reset_req, host_hard_reset_req, host_present_n, host_power,
        output host_req, host_ack, pd_host_out, pd_host_oe,
        input board_ack, board_ack_oe, board_req, board_req_oe, parallel_data_bus
    );
endinterface : hpl_link_if
`default_nettype wire

// [hpl_pkg.sv]
// Shared constants and types for the parallel host link.
// Assumes both ends run on one system clock, MCLK at 125 MHz.
package hpl_pkg;
    localparam int HPL_DATA_W = 8;
    localparam int HPL_ADDR_W = 3;
    localparam int HPL_SYNC_STAGES = 2;
    localparam int HPL_PWR_LINES = 3;
    localparam int HPL_CLK_MHZ = 125;
    // Least width of a reset request pulse driven to the processor.
    localparam int HPL_RST_PULSE_NS = 64;
    localparam int HPL_RST_PULSE_CYC = (HPL_RST_PULSE_NS * HPL_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] HPL_RST_CNT_ZERO = 8'h00;
    localparam logic [HPL_DATA_W-1:0] HPL_DATA_ZERO = 8'h00;
    localparam logic [1:0] HPL_BUF_DEPTH = 2'h2;
    // Cycles a board request stands before the board drives data, and that the host waits before taking it.
    // Two flip-flops each way mean a request raised by the far end can stay unseen for five cycles.
    localparam logic [2:0] HPL_GUARD_CYC = 3'h5;
    typedef enum logic [1:0] {HPL_IDLE, HPL_WAIT_ACK, HPL_WAIT_REL} hpl_hs_t;
endpackage : hpl_pkg
